/* File: design/dsbp_pkg.sv */
// Shared constants for the burst-of-four double-data-rate SRAM port.
package dsbp_pkg;
  localparam int DW        = 36;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int BEATS     = 4;
  localparam int CLK_MHZ   = 25;
  localparam int STOP_NS   = 30;
  localparam int LOCK_US   = 20;
  localparam int STOP_RAW  = (STOP_NS * CLK_MHZ + 999) / 1000;
  localparam int STOP_CYC  = (STOP_RAW < 1) ? 1 : STOP_RAW;
  localparam int LOCK_CYC  = LOCK_US * CLK_MHZ;
  localparam int IMP_PERIOD = 1024;
  localparam int LAT_PLL_ON  = 3;
  localparam int LAT_PLL_OFF = 2;
  localparam int WR_FIRST    = 2;
  localparam int LAST_BEAT   = BEATS - 1;
endpackage

/* File: design/dsbp_port.sv */
// Burst-of-four double-data-rate SRAM port, device side.
`timescale 1ns/100ps
`default_nettype none
module dsbp_port
  import dsbp_pkg::*;
#(
  parameter int AW           = 4,
  parameter int ZW           = 6,
  parameter int HALF_MAX_CYC = 4
) (
  input  wire logic          clk_in,
  input  wire logic          srst_in,
  input  wire logic          ce_in,
  input  wire logic          kpos_in,
  input  wire logic          kneg_in,
  input  wire logic          cpos_in,
  input  wire logic          cneg_in,
  input  wire logic          pll_enable_in,
  input  wire logic          addr_valid_n_in,
  input  wire logic          rd_nwr_in,
  input  wire logic [AW-1:0] addr_in,
  input  wire logic [DW-1:0] data_in,
  input  wire logic [3:0]    byte_lane_mask_n_in,
  input  wire logic [ZW-1:0] impedance_pin_in,
  output logic      [DW-1:0] data_out,
  output logic               data_oe_out,
  output logic               returned_strobe_out,
  output logic               returned_strobe_n_out,
  output logic               pll_locked_out,
  output logic      [ZW-1:0] impedance_code_out
);
  localparam int DEPTH = 1 << AW;
  localparam int SW    = 7 + AW + DW + LANES + ZW;
  localparam logic [1:0] STRAP_WAIT = 2'h2;

  typedef struct packed {
    logic [3:0]                    clk_d;
    logic                          strap_done;
    logic [1:0]                    strap_cnt;
    logic                          single_mode;
    logic                          last_acc;
    logic [1:0]                    rd_v;
    logic [1:0][AW-1:0]            rd_a;
    logic [1:0][2:0]               rd_c;
    logic [1:0]                    wr_v;
    logic [1:0][AW-1:0]            wr_a;
    logic [1:0][2:0]               wr_c;
    logic                          posted;
    logic [AW-1:0]                 stg_addr;
    logic [BEATS-1:0][DW-1:0]      stg_data;
    logic [BEATS-1:0][LANES-1:0]   stg_mask;
    logic [DEPTH-1:0][DW-1:0]      mem;
    logic [DW-1:0]                 dq;
    logic                          oe;
    logic                          strb;
    logic                          strb_n;
    logic [7:0]                    gap;
    logic [15:0]                   lock_cnt;
    logic                          locked;
    logic [9:0]                    imp_cnt;
    logic [ZW-1:0]                 imp_code;
  } dsbp_st_t;

  dsbp_st_t r, n;

  logic [SW-1:0]    s;
  logic             k_s, kn_s, c_s, cn_s, pll_s, avn_s, rnw_s;
  logic [AW-1:0]    addr_s;
  logic [DW-1:0]    data_s;
  logic [LANES-1:0] mask_s;
  logic [ZW-1:0]    imp_s;
  logic             kpos_e, kneg_e, opos_e, oneg_e, stopped, acc, emit;
  logic [2:0]       lat;

  // ************************************************************
  // Pin synchronisation
  // ************************************************************
  dsbp_sync #(.W(SW)) u_sync (
    .clk_in  (clk_in),
    .srst_in (srst_in),
    .ce_in   (ce_in),
    .d_in    ({kpos_in, kneg_in, cpos_in, cneg_in, pll_enable_in, addr_valid_n_in,
               rd_nwr_in, addr_in, data_in, byte_lane_mask_n_in, impedance_pin_in}),
    .q_out   (s)
  );
  assign {k_s, kn_s, c_s, cn_s, pll_s, avn_s, rnw_s, addr_s, data_s, mask_s, imp_s} = s;

  // Burst word address: low two bits wrap modulo four.
  function automatic logic [AW-1:0] word_addr(input logic [AW-1:0] base, input logic [1:0] beat);
    word_addr = {base[AW-1:2], 2'(base[1:0] + beat)};
  endfunction

  // Lane merge: a low mask bit lets that 9-bit lane through.
  function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
                                          input logic [LANES-1:0] m);
    merge = old;
    for (int l = 0; l < LANES; l++) begin
      if (!m[l]) begin
        merge[l*LANE_W +: LANE_W] = nw[l*LANE_W +: LANE_W];
      end
    end
  endfunction

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    logic [2:0]    c;
    logic [1:0]    b;
    logic [AW-1:0] ea, wa;
    logic [DW-1:0] rd;
    logic [1:0]    j;
    n    = r;
    c    = '0;
    b    = '0;
    ea   = '0;
    wa   = '0;
    rd   = '0;
    j    = '0;
    emit = 1'b0;
    n.clk_d = {k_s, kn_s, c_s, cn_s};
    kpos_e = k_s & ~r.clk_d[3];
    kneg_e = kn_s & ~r.clk_d[2];
    opos_e = r.single_mode ? kpos_e : (c_s & ~r.clk_d[1]);
    oneg_e = r.single_mode ? kneg_e : (cn_s & ~r.clk_d[0]);
    lat    = pll_s ? 3'(LAT_PLL_ON) : 3'(LAT_PLL_OFF);

    // The strap is caught once, after the synchroniser holds real pin levels, not its reset zeros.
    if (!r.strap_done) begin
      n.strap_cnt = 2'(r.strap_cnt + 2'h1);
      if (r.strap_cnt == STRAP_WAIT) begin
        n.strap_done  = 1'b1;
        n.single_mode = c_s & cn_s;
      end
    end
    n.strb   = r.single_mode ? k_s : c_s;
    n.strb_n = r.single_mode ? kn_s : cn_s;

    // PLL model: a stopped clock drops lock, lock returns after the settle time.
    if ((k_s != r.clk_d[3]) || (kn_s != r.clk_d[2])) begin
      n.gap = '0;
    end else if (r.gap != 8'hff) begin
      n.gap = 8'(r.gap + 8'h01);
    end
    stopped = (32'(r.gap) >= HALF_MAX_CYC + STOP_CYC);
    if (stopped || !pll_s) begin
      n.lock_cnt = '0;
      n.locked   = 1'b0;
    end else if (!r.locked) begin
      n.lock_cnt = 16'(r.lock_cnt + 16'h0001);
      n.locked   = (r.lock_cnt == 16'(LOCK_CYC - 1));
    end

    // Periodic impedance refresh, counted in input clock cycles.
    if (kpos_e) begin
      if (r.imp_cnt == 10'(IMP_PERIOD - 1)) begin
        n.imp_cnt  = '0;
        n.imp_code = imp_s;
      end else begin
        n.imp_cnt = 10'(r.imp_cnt + 10'h001);
      end
    end

    // Read launch: edges counted from the start edge, latency picks the first.
    for (int i = 0; i < 2; i++) begin
      if (r.rd_v[i] && (opos_e || oneg_e)) begin
        c = 3'(r.rd_c[i] + 3'h1);
        n.rd_c[i] = c;
        if (c >= lat) begin
          b    = 2'(c - lat);
          emit = 1'b1;
          ea   = word_addr(r.rd_a[i], b);
          if (b == 2'(LAST_BEAT)) begin
            n.rd_v[i] = 1'b0;
          end
        end
      end
    end
    rd = r.mem[ea];
    j  = 2'(ea[1:0] - r.stg_addr[1:0]);
    if (r.posted && (ea[AW-1:2] == r.stg_addr[AW-1:2])) begin
      rd = merge(rd, r.stg_data[j], r.stg_mask[j]);
    end
    if (emit) begin
      n.dq = rd;
      n.oe = 1'b1;
    end else if (opos_e) begin
      n.oe = 1'b0;
    end

    // Write capture on both input edges; the posted burst commits first.
    for (int i = 0; i < 2; i++) begin
      if (r.wr_v[i] && (kpos_e || kneg_e)) begin
        c = 3'(r.wr_c[i] + 3'h1);
        n.wr_c[i] = c;
        if (c >= 3'(WR_FIRST)) begin
          b = 2'(c - 3'(WR_FIRST));
          if (b == 2'h0) begin
            if (r.posted) begin
              for (int w = 0; w < BEATS; w++) begin
                wa = word_addr(r.stg_addr, 2'(w));
                n.mem[wa] = merge(r.mem[wa], r.stg_data[w], r.stg_mask[w]);
              end
            end
            n.posted   = 1'b0;
            n.stg_addr = r.wr_a[i];
          end
          n.stg_data[b] = data_s;
          n.stg_mask[b] = mask_s;
          if (b == 2'(LAST_BEAT)) begin
            n.wr_v[i] = 1'b0;
            n.posted  = 1'b1;
          end
        end
      end
    end

    // Command acceptance on the positive input edge only.
    acc = kpos_e && !avn_s && !r.last_acc;
    if (kpos_e) begin
      n.last_acc = acc;
    end
    if (acc && rnw_s) begin
      if (!n.rd_v[0]) begin
        n.rd_v[0] = 1'b1;
        n.rd_a[0] = addr_s;
        n.rd_c[0] = '0;
      end else begin
        n.rd_v[1] = 1'b1;
        n.rd_a[1] = addr_s;
        n.rd_c[1] = '0;
      end
    end else if (acc) begin
      if (!n.wr_v[0]) begin
        n.wr_v[0] = 1'b1;
        n.wr_a[0] = addr_s;
        n.wr_c[0] = '0;
      end else begin
        n.wr_v[1] = 1'b1;
        n.wr_a[1] = addr_s;
        n.wr_c[1] = '0;
      end
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  // With the clock enable low nothing moves, so the pins keep their state.
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign data_out              = r.dq;
  assign data_oe_out           = r.oe;
  assign returned_strobe_out   = r.strb;
  assign returned_strobe_n_out = r.strb_n;
  assign pll_locked_out        = r.locked;
  assign impedance_code_out    = r.imp_code;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in || !ce_in);

  sequence s_read_start;
    acc && rnw_s;
  endsequence

  chk_imp_period_wrap: assert property (kpos_e && r.imp_cnt == 10'(IMP_PERIOD - 1) |=> r.imp_cnt == 0)
    else $error("impedance period did not wrap");
  chk_strobe_out_clock: assert property (r.strap_done && !r.single_mode |=> returned_strobe_out == $past(c_s))
    else $error("returned strobe does not follow output clock");
  chk_strobe_in_clock: assert property (r.single_mode |=> returned_strobe_n_out == $past(kn_s))
    else $error("returned strobe does not follow input clock");
  chk_lock_after_count: assert property ($rose(r.locked) |-> $past(r.lock_cnt) == 16'(LOCK_CYC - 1))
    else $error("lock declared at wrong time");
  chk_stop_drops_lock: assert property (stopped |=> !pll_locked_out)
    else $error("stopped clock kept lock");
  chk_pll_off_unlocked: assert property (!pll_s |-> (lat == 3'(LAT_PLL_OFF)) ##1 !pll_locked_out)
    else $error("pll disabled but locked");
  chk_idle_tristate: assert property (r.rd_v == 0 && opos_e |=> !data_oe_out)
    else $error("data driven with no read");
  chk_back_req_ignored: assert property (kpos_e && r.last_acc |=>
      ($countones(r.rd_v) + $countones(r.wr_v)) <= $past($countones(r.rd_v) + $countones(r.wr_v)))
    else $error("back to back request accepted");
  chk_read_returns: assert property (s_read_start |-> ##[1:40] data_oe_out)
    else $error("read produced no data");
endmodule
`default_nettype wire

/* File: design/dsbp_sync.sv */
// Two-flop synchroniser for a bundle of pin inputs.
`timescale 1ns/100ps
`default_nettype none
module dsbp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         ce_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dsbp_sync_st_t;

  dsbp_sync_st_t r, n;

  always_comb begin
    n      = r;
    n.meta = d_in;
    n.sync = r.meta;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      r <= '0;
    end else if (ce_in) begin
      r <= n;
    end
  end

  assign q_out = r.sync;
endmodule
`default_nettype wire

/* File: verification/ddr2_sram_burst_port_bench.sv */
// Self-checking bench for the burst-of-four SRAM port driven by the controller model.
`timescale 1ns/100ps
`default_nettype none
module ddr2_sram_burst_port_bench
  import dsbp_pkg::*;
();
  // ********************
  // Wiring
  // ********************
  logic               clk_in = 1'b0;
  logic               srst_in = 1'b1;
  logic               pll_en = 1'b0;
  logic               ce = 1'b1;
  logic [5:0]         zpin = 6'h00;
  wire logic          kp, kn, cp, cn, avn, rdw, oe, cq, cqn, lock;
  wire logic [3:0]    addr, mask;
  wire logic [DW-1:0] din, dout;
  wire logic [5:0]    zcode;
  logic [DW-1:0]      mem [16];
  logic [DW-1:0]      hold;
  int                 bad_count = 0;
  int                 checks_done = 0;
  int                 n;
  dsbp_ctrl_model ctrl (.clk_in(clk_in), .kpos_out(kp), .kneg_out(kn), .cpos_out(cp), .cneg_out(cn),
    .addr_valid_n_out(avn), .rd_nwr_out(rdw), .addr_out(addr), .data_out(din), .byte_lane_mask_n_out(mask));
  dsbp_port dut (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce),
    .kpos_in(kp), .kneg_in(kn), .cpos_in(cp), .cneg_in(cn), .pll_enable_in(pll_en), .addr_valid_n_in(avn),
    .rd_nwr_in(rdw), .addr_in(addr), .data_in(din), .byte_lane_mask_n_in(mask), .impedance_pin_in(zpin),
    .data_out(dout), .data_oe_out(oe), .returned_strobe_out(cq), .returned_strobe_n_out(cqn),
    .pll_locked_out(lock), .impedance_code_out(zcode));
  initial begin
    forever #20 clk_in = ~clk_in;
  end
  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Waits on the lock flag, or on the impedance code when z is set.
  task automatic wait_on(input logic z, input logic [5:0] v, output int c);
    for (c = 0; z ? zcode !== v : lock !== v[0]; c++) begin
      if (c == 9000) begin
        bad_count++;
        $display("[FAIL] %0t wait ran out", $time);
        finish_test();
      end
      @(negedge clk_in);
    end
  endtask
  // Word i carries base plus i; a set dup puts a second request on the very next K rise.
  task automatic wr(input logic [3:0] a, input logic [DW-1:0] b, input logic [15:0] ms, input logic dup);
    logic [DW-1:0] w;
    logic [3:0]    k;
    logic [3:0]    ea;
    ctrl.wait_ph(3'h6);
    ctrl.cmd(1'b0, a);
    ctrl.wait_ph(3'h2);
    ctrl.idle();
    for (int i = 0; i < BEATS; i++) begin
      w = b + DW'(i);
      k = ms[4*i +: 4];
      ea = {a[3:2], a[1:0] + 2'(i)};
      ctrl.wait_ph(i[0] ? 3'h2 : 3'h6);
      if (i == 0 && dup) ctrl.cmd(1'b0, a ^ 4'h5);
      if (i == 1) ctrl.idle();
      ctrl.word(w, k);
      for (int l = 0; l < LANES; l++) begin
        if (!k[l]) mem[ea][l*LANE_W +: LANE_W] = w[l*LANE_W +: LANE_W];
      end
    end
    ctrl.wait_ph(3'h6);
    ctrl.word(~w, 4'hf);
  endtask
  // Samples sit five cycles after each output pin edge, clear of the next update.
  task automatic rd(input logic [3:0] a, input logic pll);
    int f;
    f = pll ? 1 : 0;
    ctrl.wait_ph(3'h6);
    ctrl.cmd(1'b1, a);
    ctrl.wait_ph(3'h2);
    ctrl.idle();
    ctrl.wait_ph(3'h1);
    chk1(oe, 1'b0, "oe early");
    for (int s = 0; s <= 4 + 2 * f; s++) begin
      ctrl.wait_ph(s[0] ? 3'h1 : 3'h5);
      chk1(cq, s[0] == 1'b0, "strobe");
      chk1(cqn, s[0] == 1'b1, "strobe_n");
      chk1(oe, s >= f && s <= 3 + 2 * f, "oe");
      if (s >= f && s < f + 4) chk(dout, mem[{a[3:2], a[1:0] + 2'(s - f)}], "word");
    end
  endtask
  // ********************
  // Sequence
  // ********************
  initial begin
    for (int i = 0; i < 16; i++) mem[i] = {DW{1'b0}};
    repeat (16) @(negedge clk_in);
    srst_in = 1'b0;
    repeat (8) @(negedge clk_in);
    chk1(oe, 1'b0, "oe after reset");
    wr(4'h1, 36'h123456789, 16'h0000, 1'b0);
    wr(4'h6, 36'habcdef012, 16'ha5ef, 1'b1);
    rd(4'h1, 1'b0);
    rd(4'h6, 1'b0);
    chk1(lock, 1'b0, "lock with pll off");
    pll_en = 1'b1;
    wait_on(1'b0, 6'h01, n);
    rd(4'h6, 1'b1);
    hold = dout;
    ctrl.run = 1'b0;
    wait_on(1'b0, 6'h00, n);
    chk1(n <= 12, 1'b1, "pll reset late");
    chk(dout, hold, "data held while stopped");
    ctrl.run = 1'b1;
    wait_on(1'b0, 6'h01, n);
    chk1(n >= 498 && n <= 515, 1'b1, "relock time");
    // A low clock enable freezes every register, the returned strobe included.
    ce = 1'b0;
    hold[0] = cq;
    repeat (8) begin
      @(negedge clk_in);
      chk1(cq, hold[0], "strobe frozen");
    end
    ce = 1'b1;
    zpin = 6'h2a;
    wait_on(1'b1, 6'h2a, n);
    zpin = 6'h15;
    wait_on(1'b1, 6'h15, n);
    chk1(n >= 8180 && n <= 8200, 1'b1, "impedance period");
    // Second reset with both output clocks tied high straps single-timebase mode.
    srst_in = 1'b1;
    ctrl.single = 1'b1;
    repeat (4) @(negedge clk_in);
    srst_in = 1'b0;
    for (int i = 0; i < 16; i++) mem[i] = {DW{1'b0}};
    repeat (8) @(negedge clk_in);
    chk1(oe, 1'b0, "oe after second reset");
    wr(4'h3, 36'h0f0f0f0f0, 16'h0000, 1'b0);
    rd(4'h3, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire

/* File: verification/dsbp_ctrl_model.sv */
// Controller-side model: pin clocks, commands, write data and lane masks.
`timescale 1ns/100ps
`default_nettype none
module dsbp_ctrl_model
  import dsbp_pkg::*;
(
  input  wire logic          clk_in,
  output logic               kpos_out,
  output logic               kneg_out,
  output logic               cpos_out,
  output logic               cneg_out,
  output logic               addr_valid_n_out,
  output logic               rd_nwr_out,
  output logic [3:0]         addr_out,
  output logic [DW-1:0]      data_out,
  output logic [3:0]         byte_lane_mask_n_out
);
  // ********************
  // Pin clocks and drive
  // ********************
  logic [2:0] ph     = 3'h0;
  logic       run    = 1'b1;
  logic       single = 1'b0;
  // The pin clock is a scaled stand-in held at one fixed legal rate while run is high.
  always @(negedge clk_in) begin
    ph <= ph + 3'h1;
  end
  // Parked clocks sit high and equal, the quickest state to restart from.
  assign kpos_out = !run || ph < 3'h4;
  assign kneg_out = !run || ph >= 3'h4;
  // Output clocks run with zero skew to the input pair; tying both high straps single mode.
  assign cpos_out = single || kpos_out;
  assign cneg_out = single || kneg_out;
  initial begin
    addr_valid_n_out = 1'b1;
    rd_nwr_out = 1'b0;
    addr_out = 4'h0;
    data_out = {DW{1'b0}};
    byte_lane_mask_n_out = 4'hf;
  end
  task automatic wait_ph(input logic [2:0] p);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_in);
      #1;
      if (ph == p) break;
    end
  endtask
  // One bank on this strobe; values change two cycles clear of every pin edge.
  task automatic cmd(input logic rd, input logic [3:0] a);
    addr_valid_n_out = 1'b0;
    rd_nwr_out = rd;
    addr_out = a;
  endtask
  // A released bus shows the inverse of its last value rather than holding it.
  task automatic idle();
    addr_valid_n_out = 1'b1;
    rd_nwr_out = ~rd_nwr_out;
    addr_out = ~addr_out;
  endtask
  task automatic word(input logic [DW-1:0] d, input logic [3:0] m);
    data_out = d;
    byte_lane_mask_n_out = m;
  endtask
endmodule
`default_nettype wire
